// >>> hw/pmr_map.svh
// register map, field positions, reset values and latency counts
`ifndef PMR_MAP_SVH
`define PMR_MAP_SVH
// register indices; byte address is four times the index
`define PMR_ADV_IDX 8'h04
`define PMR_PCS_IDX 8'h16
`define PMR_CTL_IDX 8'h1c
// pcs config fields
`define PMR_FX_BIT 6
`define PMR_FEF_BIT 3
`define PMR_SCB_BIT 1
`define PMR_DSB_BIT 0
`define PMR_PCS_WMASK 8'h4b
`define PMR_PCS_FX_SET 8'h4b
`define PMR_PCS_RST 8'h00
// advertisement: bits 4:0 fixed selector, bits 8:5 abilities
`define PMR_ADV_SEL 5'h01
`define PMR_ADV_RST 4'hf
`define PMR_ADV_AN00 4'h3
`define PMR_ADV_AN01 4'hc
`define PMR_ADV_AN10 4'h8
`define PMR_ADV_AN11 4'hf
// control register fields
`define PMR_CTL_RMII_BIT 0
`define PMR_CTL_NEG_BIT 1
`define PMR_CTL_FSPD_BIT 2
`define PMR_CTL_FDPX_BIT 3
`define PMR_CTL_RST 4'h3
// timing: latencies in tenths of a bit time, bit time and clock in ps
`define PMR_BIT_PS 10000
`define PMR_CORE_PS 5000
`define PMR_CCYC(t) (((t) * `PMR_BIT_PS) / (10 * `PMR_CORE_PS))
`define PMR_LCYC(t, b) ((t) / (10 * (b)))
`define PMR_R_ON_TP 185
`define PMR_R_ON_FX 90
`define PMR_R_OFF_TP 270
`define PMR_R_OFF_FX 170
`define PMR_R_DAT_TP 380
`define PMR_R_DAT_FX 270
`define PMR_M_ON_TP 190
`define PMR_M_ON_FX 90
`define PMR_M_OFF_TP 260
`define PMR_M_OFF_FX 160
`define PMR_M_DAT_TP 560
`define PMR_M_DAT_FX 460
`define PMR_R_TX 110
`define PMR_M_TX 130
`define PMR_R_BITS 2
`define PMR_M_BITS 4
`endif

// >>> hw/pmr_pkg.sv
// types shared by the media and receive interface block
package pmr_pkg;
	// receive nibble toward the mac (rmii uses the low two bits)
	typedef struct packed {
		logic       err;
		logic [3:0] data;
		logic       valid;
	} pmr_rx_t;
	// transmit nibble from the mac
	typedef struct packed {
		logic       en;
		logic [3:0] data;
	} pmr_tx_t;
	// resolved speed and duplex
	typedef struct packed {
		logic speed100;
		logic full_dpx;
	} pmr_mode_t;
	// carrier sense sequencer
	typedef enum logic [2:0] {
		CRS_IDLE,
		CRS_WAIT_ON,
		CRS_CARRIER,
		CRS_WAIT_OFF,
		CRS_TAIL
	} pmr_crs_t;
endpackage

// >>> hw/pmr_top.sv
// media selection, negotiation straps and mac side receive/transmit timing
//
// Our own choices: the placing of the registers and the APB register port.
`include "pmr_map.svh"
`timescale 1ns/10ps
`default_nettype none

module pmr_top
	import pmr_pkg::*;
#(
	parameter int RX_DEPTH = `PMR_LCYC(`PMR_R_DAT_TP, `PMR_R_BITS),
	parameter int TX_DEPTH = `PMR_LCYC(`PMR_R_TX, `PMR_R_BITS)
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        link_clk,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        med_jk,
	input  wire logic        med_tr,
	input  wire logic [3:0]  partner_abil,
	input  wire logic        negotiation_enable_strap,
	input  wire logic        negotiation_select_strap1,
	input  wire logic        negotiation_select_strap0,
	input  wire pmr_rx_t     rx_in,
	input  wire pmr_tx_t     tx_in,
	output var  pmr_rx_t     rx_out,
	output var  pmr_tx_t     tx_sym,
	input  wire logic        rx_er_i,
	output var  logic        rx_er_o,
	output var  logic        rx_er_oe,
	output var  logic        crs_dv,
	output var  logic        mac_ref_clk,
	output var  pmr_mode_t   link_mode
);

	////////////////////////////////////////////////////////////////////
	// registers and state
	logic [7:0]  pcs_q;          // pcs config bits
	logic [3:0]  adv_q;          // advertised abilities
	logic [3:0]  ctl_q;          // rmii, negotiation, forced mode
	logic        strap_done_q;   // straps taken after reset
	logic [3:0]  s1_q;           // strap sync stage 1
	logic [3:0]  s2_q;           // strap sync stage 2
	logic [3:0]  s3_q;           // strap sync stage 3
	logic [3:0]  sf_q;           // filtered strap levels
	logic        pready_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	pmr_crs_t    crs_st_q;
	logic [7:0]  cnt_q;          // carrier delay counter
	logic        crs_q;
	logic [2:0]  div_q;          // reference clock divider
	logic        mclk_q;
	pmr_mode_t   mode_q;
	logic        rmii;
	logic        fiber;
	assign rmii  = ctl_q[`PMR_CTL_RMII_BIT];
	assign fiber = pcs_q[`PMR_FX_BIT];

	////////////////////////////////////////////////////////////////////
	// apb slave: one wait state, unmapped words answer with pslverr
	logic [7:0]  idx;
	logic        hit;
	logic        acc;
	logic        wr_fire;
	logic [31:0] rd_data;
	assign idx = paddr[9:2];
	assign hit = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0)
		&& (idx == `PMR_ADV_IDX || idx == `PMR_PCS_IDX || idx == `PMR_CTL_IDX);
	assign acc = psel && penable;
	assign wr_fire = acc && pready_q && pwrite && hit;

	// read mux, unused bits read zero
	always_comb begin
		rd_data = 32'h0;
		case (idx)
			`PMR_ADV_IDX: rd_data = {23'h0, adv_q, `PMR_ADV_SEL};
			`PMR_PCS_IDX: rd_data = {24'h0, pcs_q};
			`PMR_CTL_IDX: rd_data = {19'h0, crs_q, 2'h0, mode_q, 4'h0, ctl_q};
			default:      rd_data = 32'h0;
		endcase
	end

	// answer one cycle into the access phase
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= acc && !pready_q;
			if (acc && !pready_q) begin
				// refused reads answer zero, never the word at the aliased index
				prdata_q  <= (pwrite || !hit) ? 32'h0 : rd_data;
				pslverr_q <= !hit;
			end
		end
	end
	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	////////////////////////////////////////////////////////////////////
	// strap pins: three flops, a change counts once stages 2 and 3 agree
	logic [3:0] strap_pin;
	assign strap_pin = {negotiation_enable_strap, negotiation_select_strap1,
		negotiation_select_strap0, rx_er_i};
	always_ff @(posedge core_clk) begin
		s1_q <= strap_pin;
		s2_q <= s1_q;
		s3_q <= s2_q;
		sf_q <= (s3_q & ~(s2_q ^ s3_q)) | (sf_q & (s2_q ^ s3_q));
	end

	// straps are taken on the first edge after reset release
	always_ff @(posedge core_clk) begin
		strap_done_q <= !reset;
	end

	////////////////////////////////////////////////////////////////////
	// pcs config: media strap, then software writes
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pcs_q <= `PMR_PCS_RST;
		end else if (!strap_done_q) begin
			// pulled low selects fiber and its bypass bits
			pcs_q <= sf_q[0] ? `PMR_PCS_RST : `PMR_PCS_FX_SET;
		end else if (wr_fire && idx == `PMR_PCS_IDX) begin
			pcs_q <= pwdata[7:0] & `PMR_PCS_WMASK;
		end
	end

	// advertisement: strap table at reset, then writable
	always_ff @(posedge core_clk) begin
		if (reset) begin
			adv_q <= `PMR_ADV_RST;
		end else if (!strap_done_q) begin
			if (sf_q[3]) begin
				case (sf_q[2:1])
					2'h0:    adv_q <= `PMR_ADV_AN00;
					2'h1:    adv_q <= `PMR_ADV_AN01;
					2'h2:    adv_q <= `PMR_ADV_AN10;
					default: adv_q <= `PMR_ADV_AN11;
				endcase
			end else begin
				// forced: only the forced ability is advertised
				adv_q <= 4'h1 << sf_q[2:1];
			end
		end else if (wr_fire && idx == `PMR_ADV_IDX) begin
			adv_q <= pwdata[8:5];
		end
	end

	// control: interface select, negotiation enable, forced mode
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctl_q <= `PMR_CTL_RST;
		end else if (!strap_done_q) begin
			ctl_q <= {sf_q[1], sf_q[2], sf_q[3], ctl_q[0]};
		end else if (wr_fire && idx == `PMR_CTL_IDX) begin
			ctl_q <= pwdata[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// mode resolution: highest common ability, or the forced one
	logic [3:0] common;
	assign common = ctl_q[`PMR_CTL_NEG_BIT] ? (adv_q & partner_abil)
		: (4'h1 << {ctl_q[`PMR_CTL_FSPD_BIT], ctl_q[`PMR_CTL_FDPX_BIT]});
	always_ff @(posedge core_clk) begin
		if (reset) begin
			mode_q <= '0;
		end else if (common[3]) begin
			mode_q <= '{speed100: 1'b1, full_dpx: 1'b1};
		end else if (common[2]) begin
			mode_q <= '{speed100: 1'b1, full_dpx: 1'b0};
		end else if (common[1]) begin
			mode_q <= '{speed100: 1'b0, full_dpx: 1'b1};
		end else begin
			mode_q <= '0; // no overlap falls back to the slowest mode
		end
	end
	assign link_mode = mode_q;

	////////////////////////////////////////////////////////////////////
	// reference clock for the mac: 50 mhz rmii, 25 mhz mii
	always_ff @(posedge core_clk) begin
		if (reset) begin
			div_q  <= 3'h0;
			mclk_q <= 1'b0;
		end else begin
			div_q  <= div_q + 3'h1;
			mclk_q <= rmii ? div_q[1] : div_q[2];
		end
	end
	assign mac_ref_clk = mclk_q;

	////////////////////////////////////////////////////////////////////
	// carrier sense runs on the fast core clock, so it moves
	// independently of the reference clock edges
	logic [7:0] on_cyc;
	logic [7:0] off_cyc;
	logic [7:0] tail_cyc;
	always_comb begin
		if (rmii) begin
			on_cyc  = fiber ? 8'(`PMR_CCYC(`PMR_R_ON_FX)) : 8'(`PMR_CCYC(`PMR_R_ON_TP));
			off_cyc = fiber ? 8'(`PMR_CCYC(`PMR_R_OFF_FX)) : 8'(`PMR_CCYC(`PMR_R_OFF_TP));
		end else begin
			on_cyc  = fiber ? 8'(`PMR_CCYC(`PMR_M_ON_FX)) : 8'(`PMR_CCYC(`PMR_M_ON_TP));
			off_cyc = fiber ? 8'(`PMR_CCYC(`PMR_M_OFF_FX)) : 8'(`PMR_CCYC(`PMR_M_OFF_TP));
		end
		// rmii tail covers the data still in flight
		tail_cyc = fiber ? 8'(`PMR_CCYC(`PMR_R_DAT_FX - `PMR_R_OFF_FX))
			: 8'(`PMR_CCYC(`PMR_R_DAT_TP - `PMR_R_OFF_TP));
	end

	// a new start is ignored until the sequencer is back to idle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			crs_st_q <= CRS_IDLE;
			cnt_q    <= 8'h0;
			crs_q    <= 1'b0;
		end else begin
			case (crs_st_q)
				CRS_IDLE: begin
					if (med_jk) begin
						crs_st_q <= CRS_WAIT_ON;
						cnt_q    <= on_cyc - 8'h1;
					end
				end
				CRS_WAIT_ON: begin
					if (cnt_q == 8'h0) begin
						crs_q    <= 1'b1;
						crs_st_q <= CRS_CARRIER;
					end else begin
						cnt_q <= cnt_q - 8'h1;
					end
				end
				CRS_CARRIER: begin
					if (med_tr) begin
						crs_st_q <= CRS_WAIT_OFF;
						cnt_q    <= off_cyc - 8'h1;
					end
				end
				CRS_WAIT_OFF: begin
					if (cnt_q == 8'h0) begin
						crs_q    <= 1'b0;
						crs_st_q <= rmii ? CRS_TAIL : CRS_IDLE;
						cnt_q    <= tail_cyc - 8'h1;
					end else begin
						cnt_q <= cnt_q - 8'h1;
					end
				end
				CRS_TAIL: begin
					// toggle once per reference period while data drains
					if (cnt_q == 8'h0) begin
						crs_q    <= 1'b0;
						crs_st_q <= CRS_IDLE;
					end else begin
						cnt_q <= cnt_q - 8'h1;
						if (cnt_q[1:0] == 2'h0) begin
							crs_q <= !crs_q;
						end
					end
				end
				default: crs_st_q <= CRS_IDLE;
			endcase
		end
	end
	assign crs_dv = crs_q;

	////////////////////////////////////////////////////////////////////
	// link domain: reset and mode levels cross in
	logic [1:0] lrst_q;      // {filtered reset, reset sync stage 1}
	logic       lrst2_q;     // reset sync stage 2
	logic       lrst3_q;     // reset sync stage 3
	logic [1:0] l1_q;        // mode sync stage 1
	logic [1:0] l2_q;
	logic [1:0] l3_q;
	logic [1:0] lf_q;        // filtered {rmii, fiber}
	logic       oe_q;
	always_ff @(posedge link_clk) begin
		lrst_q[0] <= reset;
		lrst2_q   <= lrst_q[0];
		lrst3_q   <= lrst2_q;
		// reset only counts once stages 2 and 3 agree
		lrst_q[1] <= (lrst2_q == lrst3_q) ? lrst3_q : lrst_q[1];
		l1_q   <= {rmii, fiber};
		l2_q   <= l1_q;
		l3_q   <= l2_q;
		lf_q   <= (l3_q & ~(l2_q ^ l3_q)) | (lf_q & (l2_q ^ l3_q));
	end

	// receive error pin released during reset so the strap can be read
	always_ff @(posedge link_clk) begin
		oe_q <= !lrst_q[1];
	end
	assign rx_er_oe = oe_q;

	// receive delay line, tap picked by interface and media
	pmr_rx_t    rxl_q [RX_DEPTH];
	pmr_rx_t    rx_q;
	logic [4:0] rx_tap;
	always_comb begin
		if (lf_q[1]) begin
			rx_tap = lf_q[0] ? 5'(`PMR_LCYC(`PMR_R_DAT_FX, `PMR_R_BITS) - 1)
				: 5'(`PMR_LCYC(`PMR_R_DAT_TP, `PMR_R_BITS) - 1);
		end else begin
			rx_tap = lf_q[0] ? 5'(`PMR_LCYC(`PMR_M_DAT_FX, `PMR_M_BITS) - 1)
				: 5'(`PMR_LCYC(`PMR_M_DAT_TP, `PMR_M_BITS) - 1);
		end
	end

	for (genvar gi = 0; gi < RX_DEPTH; gi++) begin : g_rxl
		always_ff @(posedge link_clk) begin
			if (lrst_q[1]) begin
				rxl_q[gi] <= '0;
			end else begin
				rxl_q[gi] <= (gi == 0) ? rx_in : rxl_q[(gi == 0) ? 0 : gi - 1];
			end
		end
	end

	// outputs launched from the link clock rising edge
	always_ff @(posedge link_clk) begin
		if (lrst_q[1]) begin
			rx_q <= '0;
		end else begin
			rx_q <= rxl_q[rx_tap];
		end
	end
	assign rx_out  = rx_q;
	assign rx_er_o = rx_q.err;

	// transmit: captured on the rising edge, symbol leaves later
	pmr_tx_t    txl_q [TX_DEPTH];
	pmr_tx_t    tx_q;
	logic [2:0] tx_tap;
	assign tx_tap = lf_q[1] ? 3'(`PMR_LCYC(`PMR_R_TX, `PMR_R_BITS) - 1)
		: 3'(`PMR_LCYC(`PMR_M_TX, `PMR_M_BITS) - 1);
	for (genvar gt = 0; gt < TX_DEPTH; gt++) begin : g_txl
		always_ff @(posedge link_clk) begin
			if (lrst_q[1]) begin
				txl_q[gt] <= '0;
			end else begin
				txl_q[gt] <= (gt == 0) ? tx_in : txl_q[(gt == 0) ? 0 : gt - 1];
			end
		end
	end
	always_ff @(posedge link_clk) begin
		if (lrst_q[1]) begin
			tx_q <= '0;
		end else begin
			tx_q <= txl_q[tx_tap];
		end
	end
	assign tx_sym = tx_q;

	////////////////////////////////////////////////////////////////////
	// assertions
	logic idle_jk;
	assign idle_jk = crs_st_q == CRS_IDLE && med_jk;

	rmii_tp_on_a: assert property (@(posedge core_clk) disable iff (reset)
		(idle_jk && rmii && !fiber) |-> ##37 !crs_q ##1 crs_q)
		else $error("rmii twisted pair carrier on delay wrong");
	rmii_fx_on_a: assert property (@(posedge core_clk) disable iff (reset)
		(idle_jk && rmii && fiber) |-> ##18 !crs_q ##1 crs_q)
		else $error("rmii fiber carrier on delay wrong");
	rmii_tp_off_a: assert property (@(posedge core_clk) disable iff (reset)
		(crs_st_q == CRS_CARRIER && med_tr && rmii && !fiber)
		|-> ##54 crs_q ##1 !crs_q)
		else $error("rmii carrier off delay wrong");
	mii_crs_on_a: assert property (@(posedge core_clk) disable iff (reset)
		(idle_jk && !rmii && !fiber) |-> ##38 !crs_q ##1 crs_q)
		else $error("mii carrier on delay wrong");
	tail_toggle_a: assert property (@(posedge core_clk) disable iff (reset)
		(crs_st_q == CRS_TAIL && cnt_q[1:0] != 2'h0) |=> $stable(crs_q))
		else $error("carrier tail toggled off step");
	fx_strap_a: assert property (@(posedge core_clk) disable iff (reset)
		(!strap_done_q && !sf_q[0]) |=> pcs_q == `PMR_PCS_FX_SET)
		else $error("fiber strap did not set bypass bits");
	adv_strap_a: assert property (@(posedge core_clk) disable iff (reset)
		(!strap_done_q && sf_q[3:1] == 3'h5) |=> adv_q == `PMR_ADV_AN01)
		else $error("advertisement strap wrong");
	fx_write_a: assert property (@(posedge core_clk) disable iff (reset)
		(wr_fire && idx == `PMR_PCS_IDX) |=> fiber == $past(pwdata[6]))
		else $error("fiber enable write lost");
	resolve_a: assert property (@(posedge core_clk) disable iff (reset)
		(ctl_q[1] && adv_q[3] && partner_abil[3]) |=> mode_q == 2'h3)
		else $error("highest common mode not chosen");
	ref_clk_a: assert property (@(posedge core_clk) disable iff (reset)
		(rmii && $past(rmii) && $rose(mclk_q)) |-> ##2 $fell(mclk_q))
		else $error("rmii reference clock period wrong");
	rmii_rx_lat_a: assert property (@(posedge link_clk) disable iff (lrst_q[1])
		(lf_q == 2'h2 && rx_in.valid) |-> ##20 rx_q.valid)
		else $error("rmii receive latency wrong");
	mii_rx_lat_a: assert property (@(posedge link_clk) disable iff (lrst_q[1])
		(lf_q == 2'h0 && rx_in.valid) |-> ##15 rx_q.valid)
		else $error("mii receive latency wrong");
	mii_tx_lat_a: assert property (@(posedge link_clk) disable iff (lrst_q[1])
		(lf_q == 2'h0 && tx_in.en) |-> ##4 tx_q.en)
		else $error("mii transmit latency wrong");

	carrier_cycle_c: cover property (@(posedge core_clk) disable iff (reset)
		crs_st_q == CRS_TAIL ##1 crs_st_q == CRS_IDLE);
	fiber_strap_c: cover property (@(posedge core_clk) disable iff (reset)
		!strap_done_q && !sf_q[0]);
	rx_frame_c: cover property (@(posedge link_clk) disable iff (lrst_q[1])
		rx_q.valid ##1 !rx_q.valid);

endmodule
`default_nettype wire

// >>> sim/pmr_mac_model.sv
// mac side model: drives link stimulus frames and samples receive outputs
`timescale 1ns/10ps
`default_nettype none

module pmr_mac_model
	import pmr_pkg::*;
(
	input  wire logic    link_clk,
	input  wire logic    rx_go,
	input  wire logic    tx_go,
	input  wire pmr_rx_t rx_out,
	output var  pmr_rx_t rx_in,
	output var  pmr_tx_t tx_in,
	output var  pmr_rx_t rx_cap
);
	////////////////////////////////////////////////////////////////////////
	// start quiet so nothing unknown reaches the link side
	initial begin
		rx_in = '0;
		tx_in = '0;
		rx_cap = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// one-cycle frame on request; idle data flips every cycle so a stale
	// value can never pass for a delayed copy of the frame
	always @(posedge link_clk) begin
		rx_in <= rx_go ? pmr_rx_t'({1'b1, 4'h6, 1'b1}) : pmr_rx_t'({1'b0, ~rx_in.data, 1'b0});
		tx_in <= tx_go ? pmr_tx_t'({1'b1, 4'h9}) : pmr_tx_t'({1'b0, ~tx_in.data});
		rx_cap <= rx_out;
	end
endmodule

`default_nettype wire

// >>> sim/phy_media_and_rx_interface_cfg_bench.sv
// bench: register access, media straps, negotiation, carrier and link latencies
`timescale 1ns/10ps
`default_nettype none

module phy_media_and_rx_interface_cfg_bench;
	import pmr_pkg::*;
	logic        core_clk;      // 200 mhz core clock
	logic        link_clk;      // 30 ns link clock, own phase
	logic        reset;         // synchronous, active high
	logic        psel;          // apb request
	logic        penable;       // apb access phase
	logic        pwrite;        // apb direction
	logic [11:0] paddr;         // apb byte address
	logic [31:0] pwdata;        // apb write data
	logic [31:0] prdata;        // apb read data
	logic        pready;        // apb completion
	logic        pslverr;       // apb refusal
	logic [31:0] rd;            // last read word
	logic        err;           // last refusal flag
	logic        med_jk;        // start symbol seen
	logic        med_tr;        // end symbol seen
	logic [3:0]  partner_abil;  // partner abilities
	logic [2:0]  st;            // negotiation straps {enable, sel1, sel0}
	logic        rx_pull;       // board pull on the receive error pin
	logic        rx_er_i;       // resolved pin level
	logic        rx_er_o;       // driven pin value
	logic        rx_er_oe;      // pin drive enable
	logic        crs_dv;        // carrier sense toward mac
	logic        mac_ref_clk;   // divided reference clock
	logic        rx_go;         // ask model for a receive frame
	logic        tx_go;         // ask model for a transmit frame
	pmr_rx_t     rx_in;         // receive stream in
	pmr_rx_t     rx_out;        // receive stream out
	pmr_rx_t     rx_cap;        // model's sampled copy
	pmr_tx_t     tx_in;         // transmit stream in
	pmr_tx_t     tx_sym;        // transmit stream out
	pmr_mode_t   link_mode;     // resolved mode
	int          num_errors;    // mismatches seen
	int          n_tests;       // comparisons made

	// pin resolves to the driver while enabled, else to the board pull
	assign rx_er_i = rx_er_oe ? rx_er_o : rx_pull;

	////////////////////////////////////////////////////////////////////////
	// clocks; link clock offset so its edges never line up with the core
	initial core_clk = 1'b0;
	always #2.5 core_clk = ~core_clk;
	initial begin
		link_clk = 1'b0;
		#3.3;
		forever #15 link_clk = ~link_clk;
	end

	pmr_top dut_u (
		.core_clk(core_clk), .reset(reset), .link_clk(link_clk), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .med_jk(med_jk),
		.med_tr(med_tr), .partner_abil(partner_abil),
		.negotiation_enable_strap(st[2]), .negotiation_select_strap1(st[1]),
		.negotiation_select_strap0(st[0]), .rx_in(rx_in), .tx_in(tx_in),
		.rx_out(rx_out), .tx_sym(tx_sym), .rx_er_i(rx_er_i), .rx_er_o(rx_er_o),
		.rx_er_oe(rx_er_oe), .crs_dv(crs_dv), .mac_ref_clk(mac_ref_clk),
		.link_mode(link_mode)
	);

	pmr_mac_model mac_u (
		.link_clk(link_clk), .rx_go(rx_go), .tx_go(tx_go), .rx_out(rx_out),
		.rx_in(rx_in), .tx_in(tx_in), .rx_cap(rx_cap)
	);

	////////////////////////////////////////////////////////////////////////
	// comparison, verdict and hang guard
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task conclude;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task tmo;
		num_errors++;
		$display("[FAIL] %0t wait ran out", $time);
		conclude;
	endtask

	////////////////////////////////////////////////////////////////////////
	// apb master: request held until pready is sampled high
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
			tmo;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk(err, e);
	endtask

	// reset with straps; long enough for the link side sync as well
	task do_reset(input logic fx, input logic [2:0] s);
		@(posedge core_clk);
		reset <= 1'b1;
		rx_pull <= ~fx;
		st <= s;
		repeat (40) @(posedge core_clk);
		reset <= 1'b0;
		repeat (8) @(posedge link_clk);
	endtask

	// edges from the sampling edge until the watched output reaches lvl
	task count(input int sel, input logic lvl, output int c);
		for (c = 0; c < 200; c++) begin
			if (sel == 0)
				@(negedge core_clk);
			else
				@(negedge link_clk);
			if ((sel == 0 ? crs_dv : sel == 1 ? rx_out.valid : tx_sym.en) === lvl)
				break;
		end
		if (c == 200)
			tmo;
	endtask

	////////////////////////////////////////////////////////////////////////
	// twisted pair straps, then register driven negotiation
	task t_neg;
		logic [3:0] abl [4];
		logic [1:0] ex [4];
		int         i;
		int         k;
		abl = '{4'h1, 4'h3, 4'h6, 4'hc};
		ex = '{2'b00, 2'b01, 2'b10, 2'b11};
		do_reset(1'b0, 3'b101);
		rdchk(12'h010, 32'h181, 1'b0);
		rdchk(12'h058, 32'h0, 1'b0);
		apb(1'b0, 12'h070, 32'h0);
		chk(rd[3:0], 4'hb);
		apb(1'b1, 12'h010, 32'h1ff);
		rdchk(12'h010, 32'h1e1, 1'b0);
		for (k = 0; k < 4; k++) begin
			partner_abil <= abl[k];
			for (i = 0; i < 50 && link_mode !== ex[k]; i++)
				@(posedge core_clk);
			if (i == 50)
				tmo;
			chk(link_mode, ex[k]);
		end
		$display("negotiation test done");
	endtask

	// one interface/media mode: carrier timing, tail, data paths, clock
	task t_mode(input logic [31:0] ctl, pcs, input int n, m, tog, l, t, p);
		int   c;
		int   ones;
		logic pv;
		apb(1'b1, 12'h070, ctl);
		apb(1'b1, 12'h058, pcs);
		repeat (8) @(posedge link_clk);
		@(posedge core_clk);
		med_jk <= 1'b1;
		@(posedge core_clk);
		med_jk <= 1'b0;
		count(0, 1'b1, c);
		chk(c, n);
		@(posedge core_clk);
		med_tr <= 1'b1;
		@(posedge core_clk);
		med_tr <= 1'b0;
		count(0, 1'b0, c);
		chk(c, m);
		ones = 0;
		repeat (30) begin
			@(negedge core_clk);
			if (crs_dv === 1'b1)
				ones++;
		end
		chk(ones > 0, tog);
		chk(crs_dv, 1'b0);
		@(posedge link_clk);
		rx_go <= 1'b1;
		@(posedge link_clk);
		rx_go <= 1'b0;
		@(posedge link_clk);
		count(1, 1'b1, c);
		chk(c, l);
		chk({rx_er_o, rx_er_oe, rx_out.data[1:0]}, 4'b1110);
		@(negedge link_clk);
		chk(rx_cap.data[1:0], 2'b10);
		@(posedge link_clk);
		tx_go <= 1'b1;
		@(posedge link_clk);
		tx_go <= 1'b0;
		@(posedge link_clk);
		count(2, 1'b1, c);
		chk(c, t);
		chk(tx_sym.data[1:0], 2'b01);
		// period between the first two rising edges; later edges are ignored
		pv = 1'b1;
		c = -1;
		repeat (40) begin
			@(negedge core_clk);
			if (c >= 0 && c < 1000)
				c++;
			if (mac_ref_clk === 1'b1 && pv === 1'b0 && c < 1000)
				c = (c < 0) ? 0 : c + 1000;
			pv = mac_ref_clk;
		end
		chk(c - 1000, p);
		$display("mode test done");
	endtask

	// fiber strap with forced mode, media override, refused accesses
	task t_fiber;
		do_reset(1'b1, 3'b010);
		rdchk(12'h058, 32'h4b, 1'b0);
		rdchk(12'h010, 32'h81, 1'b0);
		apb(1'b0, 12'h070, 32'h0);
		chk(rd[9:0], 10'h205);
		chk(link_mode, 2'b10);
		apb(1'b1, 12'h058, 32'hff);
		rdchk(12'h058, 32'h4b, 1'b0);
		apb(1'b1, 12'h058, 32'h0);
		rdchk(12'h058, 32'h0, 1'b0);
		rdchk(12'h020, 32'h0, 1'b1);
		rdchk(12'h011, 32'h0, 1'b1);
		$display("fiber test done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		med_jk = 1'b0;
		med_tr = 1'b0;
		partner_abil = 4'hf;
		st = 3'b100;
		rx_pull = 1'b1;
		rx_go = 1'b0;
		tx_go = 1'b0;
		num_errors = 0;
		n_tests = 0;
		t_neg;
		t_mode(32'h3, 32'h00, 37, 54, 1, 19, 5, 4);
		t_mode(32'h2, 32'h00, 38, 52, 0, 14, 3, 8);
		t_mode(32'h3, 32'h40, 18, 34, 1, 13, 5, 4);
		t_mode(32'h2, 32'h40, 18, 32, 0, 11, 3, 8);
		t_fiber;
		conclude;
	end
endmodule

`default_nettype wire
